//--- core/rot_sub_alu.sv
// Combinational arithmetic for the two instructions.
// Assumes operands come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module rot_sub_alu
   import rot_sub_pkg::*;
(
   // Operation
   input  wire rot_sub_pkg::op_e    op,
   input  wire rot_sub_pkg::byte_t  operand,
   input  wire rot_sub_pkg::byte_t  acc,
   input  wire rot_sub_pkg::flags_s flags_in,
   // Results
   output rot_sub_pkg::byte_t       result,
   output rot_sub_pkg::flags_s      flags_out
);
   logic [`DATA_WIDTH:0]   diff;
   logic [`NIBBLE_WIDTH:0] ndiff;
   always_comb begin
      diff      = {1'b0, operand} - {1'b0, acc};
      ndiff     = {1'b0, operand[`NIBBLE_WIDTH-1:0]} - {1'b0, acc[`NIBBLE_WIDTH-1:0]};
      result    = operand;
      flags_out = flags_in;
      case (op)
         ROTATE_RIGHT_THROUGH_CARRY_OP: begin
            result          = {flags_in.carry, operand[`DATA_WIDTH-1:1]};
            flags_out.carry = operand[0];
         end
         LITERAL_MINUS_ACCUMULATOR_OP: begin
            result                    = diff[`DATA_WIDTH-1:0];
            // Borrow out inverted gives the carry sense
            flags_out.carry           = ~diff[`DATA_WIDTH];
            flags_out.half_carry_flag = ~ndiff[`NIBBLE_WIDTH];
            flags_out.zero            = (diff[`DATA_WIDTH-1:0] == 8'h00);
         end
         default: begin
            result    = operand;
            flags_out = flags_in;
         end
      endcase
   end
endmodule : rot_sub_alu
`default_nettype wire

//--- core/rot_sub_core.sv
// Accumulator and status flags for rotate-right and literal subtract.
// Assumes one command per clock from a decoder on the same clock;
// the register file takes the write-back port.
`timescale 1ns/100ps
`default_nettype none
module rot_sub_core
   import rot_sub_pkg::*;
(
   // Clock and reset
   input  wire logic                CLK,
   input  wire logic                RST,
   // Command
   input  wire rot_sub_pkg::cmd_s   CMD,
   // Write-back to the register file
   output rot_sub_pkg::reg_wr_s     REG_WR,
   // State
   output rot_sub_pkg::byte_t       ACC,
   output rot_sub_pkg::flags_s      FLAGS
);
   byte_t  acc_q;
   flags_s flags_q;
   reg_wr_s wr_q;
   byte_t  result;
   flags_s flags_d;

   rot_sub_alu u_alu (
      .op        (CMD.op),
      .operand   (CMD.operand),
      .acc       (acc_q),
      .flags_in  (flags_q),
      .result    (result),
      .flags_out (flags_d)
   );

   // Accumulator
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         acc_q <= `ACC_RESET;
      end else if (CMD.op == LITERAL_MINUS_ACCUMULATOR_OP) begin
         acc_q <= result;
      end else if (CMD.op == ROTATE_RIGHT_THROUGH_CARRY_OP && CMD.dest == `DEST_ACC) begin
         acc_q <= result;
      end
   end

   // Flags; rotate only moves carry, handled in the ALU
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   // Register write-back, rotate only
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_q <= '0;
      end else begin
         wr_q.reg_we   <= (CMD.op == ROTATE_RIGHT_THROUGH_CARRY_OP) && (CMD.dest == `DEST_REG);
         wr_q.reg_data <= result;
      end
   end

   assign ACC    = acc_q;
   assign FLAGS  = flags_q;
   assign REG_WR = wr_q;

   sequence s_rot_cmd;
      CMD.op == ROTATE_RIGHT_THROUGH_CARRY_OP;
   endsequence
   sequence s_sub_cmd;
      CMD.op == LITERAL_MINUS_ACCUMULATOR_OP;
   endsequence

   sequence s_idle_cmd;
      CMD.op == OP_NONE;
   endsequence
   sequence s_to_acc;
      CMD.dest == `DEST_ACC;
   endsequence
   sequence s_to_reg;
      CMD.dest == `DEST_REG;
   endsequence

   a_rot_shift_value: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd |=> (FLAGS.carry == $past(CMD.operand[0])) &&
                    (($past(CMD.dest) == `DEST_REG) || (ACC == REG_WR.reg_data)) &&
                    (REG_WR.reg_data == {$past(flags_q.carry), $past(CMD.operand[7:1])}))
      else $error("rotate result wrong");
   a_rot_dest_acc: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd and (CMD.dest == `DEST_ACC) |=> !REG_WR.reg_we && ACC == REG_WR.reg_data)
      else $error("rotate to accumulator wrong");
   a_rot_dest_reg: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd and (CMD.dest == `DEST_REG) |=> REG_WR.reg_we && $stable(ACC))
      else $error("rotate to register wrong");
   a_rot_flags_kept: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd |=> $stable(FLAGS.zero) && $stable(FLAGS.half_carry_flag))
      else $error("rotate altered other flags");
   a_sub_difference: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd |=> ACC == 8'($past(CMD.operand) - $past(acc_q)))
      else $error("subtract result wrong");
   a_sub_no_regwr: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd |=> !REG_WR.reg_we)
      else $error("subtract wrote register");
   a_sub_carry_sense: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd |=> FLAGS.carry == ($past(acc_q) <= $past(CMD.operand)))
      else $error("subtract carry wrong");
   a_sub_half_zero: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd |=> FLAGS.half_carry_flag == ($past(acc_q[3:0]) <= $past(CMD.operand[3:0])) &&
                    FLAGS.zero == (ACC == 8'h00))
      else $error("subtract half carry or zero wrong");

   // Finer checks, one behaviour each, so a failure names its cause

   a_idle_acc_kept: assert property (@(posedge CLK) disable iff (RST)
      s_idle_cmd |=>
         $stable(ACC))
      else $error("idle changed accumulator");

   a_idle_flags_kept: assert property (@(posedge CLK) disable iff (RST)
      s_idle_cmd |=>
         $stable(FLAGS))
      else $error("idle changed flags");

   a_idle_no_write: assert property (@(posedge CLK) disable iff (RST)
      s_idle_cmd |=>
         !REG_WR.reg_we)
      else $error("idle wrote register");

   a_acc_needs_cmd: assert property (@(posedge CLK) disable iff (RST)
      $changed(ACC) |->
         $past(CMD.op) != OP_NONE)
      else $error("accumulator changed without command");

   a_flags_need_cmd: assert property (@(posedge CLK) disable iff (RST)
      $changed(FLAGS) |->
         $past(CMD.op) != OP_NONE)
      else $error("flags changed without command");

   a_rot_carry_out: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd |=>
         FLAGS.carry == $past(CMD.operand[0]))
      else $error("rotate carry out wrong");

   a_rot_msb_in: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd |=>
         REG_WR.reg_data[7] == $past(FLAGS.carry))
      else $error("rotate top bit wrong");

   a_rot_low_bits: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd |=>
         REG_WR.reg_data[6:0] == $past(CMD.operand[7:1]))
      else $error("rotate low bits wrong");

   a_rot_acc_value: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd ##0 s_to_acc |=>
         ACC == {$past(FLAGS.carry), $past(CMD.operand[7:1])})
      else $error("rotate accumulator value wrong");

   a_rot_reg_value: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd ##0 s_to_reg |=>
         REG_WR.reg_we && REG_WR.reg_data == {$past(FLAGS.carry), $past(CMD.operand[7:1])})
      else $error("rotate write-back value wrong");

   a_we_from_rotate: assert property (@(posedge CLK) disable iff (RST)
      REG_WR.reg_we |->
         $past(CMD.op) == ROTATE_RIGHT_THROUGH_CARRY_OP && $past(CMD.dest) == `DEST_REG)
      else $error("write-back without rotate to register");

   a_rot_zero_kept: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd |=>
         FLAGS.zero == $past(FLAGS.zero))
      else $error("rotate altered zero");

   a_rot_half_kept: assert property (@(posedge CLK) disable iff (RST)
      s_rot_cmd |=>
         FLAGS.half_carry_flag == $past(FLAGS.half_carry_flag))
      else $error("rotate altered half carry");

   a_sub_acc_dest_reg: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd ##0 s_to_reg |=>
         ACC == 8'($past(CMD.operand) - $past(ACC)))
      else $error("subtract ignored accumulator");

   a_sub_dest_ignored: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd ##0 s_to_reg |=>
         !REG_WR.reg_we)
      else $error("subtract obeyed destination bit");

   a_sub_borrow_clear: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd ##0 (ACC > CMD.operand) |=>
         !FLAGS.carry)
      else $error("subtract borrow carry wrong");

   a_sub_no_borrow: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd ##0 (ACC <= CMD.operand) |=>
         FLAGS.carry)
      else $error("subtract no-borrow carry wrong");

   a_sub_nibble_borrow: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd ##0 (ACC[3:0] > CMD.operand[3:0]) |=>
         !FLAGS.half_carry_flag)
      else $error("subtract nibble borrow wrong");

   a_sub_nibble_ok: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd ##0 (ACC[3:0] <= CMD.operand[3:0]) |=>
         FLAGS.half_carry_flag)
      else $error("subtract nibble no-borrow wrong");

   a_sub_zero_equal: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd ##0 (ACC == CMD.operand) |=>
         FLAGS.zero && ACC == 8'h00)
      else $error("subtract zero not flagged");

   a_sub_zero_other: assert property (@(posedge CLK) disable iff (RST)
      s_sub_cmd ##0 (ACC != CMD.operand) |=>
         !FLAGS.zero)
      else $error("subtract zero flagged wrongly");
endmodule : rot_sub_core
`default_nettype wire

//--- core/rot_sub_pkg.sv
// Types shared by the rotate-right and literal-subtract datapath.
// Assumes the constants header is on the include path.
`include "rot_sub_regs.svh"
package rot_sub_pkg;
   typedef logic [`DATA_WIDTH-1:0] byte_t;
   typedef enum logic [1:0] {
      OP_NONE,
      ROTATE_RIGHT_THROUGH_CARRY_OP,
      LITERAL_MINUS_ACCUMULATOR_OP
   } op_e;
   typedef struct packed {
      logic carry;
      logic half_carry_flag;
      logic zero;
   } flags_s;
   typedef struct packed {
      op_e   op;
      logic  dest;
      byte_t operand;
   } cmd_s;
   typedef struct packed {
      logic  reg_we;
      byte_t reg_data;
   } reg_wr_s;
endpackage : rot_sub_pkg

//--- core/rot_sub_regs.svh
// Constants for the rotate-right and literal-subtract datapath.
// Assumes inclusion by the package and the datapath modules.
// Functional notes
// - Rotate right one bit; old carry enters bit 7, bit 0 becomes carry.
// - Destination bit 0 writes accumulator, 1 writes register back; only carry changes.
// - Literal subtract computes literal minus accumulator, two's complement, literal 0..255.
// - Literal subtract always writes accumulator and updates carry, half carry, zero.
`ifndef ROT_SUB_REGS_SVH
`define ROT_SUB_REGS_SVH
`define DATA_WIDTH      8
`define NIBBLE_WIDTH    4
`define ACC_RESET       8'h00
`define DEST_ACC        1'b0
`define DEST_REG        1'b1
`define OP_LATENCY      1
`endif

//--- tb/rot_sub_core_test.sv
// Self-checking bench for the rotate-right and literal-subtract datapath.
// Assumes the package, header and core are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("ERROR %s exp %h got %h", n, e, g); end end
module rot_sub_core_test;
   import rot_sub_pkg::*;
   logic    clk;
   logic    rst;
   cmd_s    cmd;
   reg_wr_s reg_wr;
   byte_t   acc;
   byte_t   acc_m;
   byte_t   res;
   flags_s  flags;
   flags_s  flg_m;
   logic    we_m;
   int      err_total;
   int      cmp_count;
   int      cycles;

   rot_sub_core dut (.CLK(clk), .RST(rst), .CMD(cmd), .REG_WR(reg_wr), .ACC(acc), .FLAGS(flags));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Whole run is well under a hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 400) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // Drive one command at the falling edge, judge after the next rising one
   task automatic step(op_e op, logic dest, byte_t k);
      cmd = '{op, dest, k};
      we_m = 1'b0;
      if (op == ROTATE_RIGHT_THROUGH_CARRY_OP) begin
         res = {flg_m.carry, k[7:1]};
         flg_m.carry = k[0];
         we_m = dest;
         if (dest == 1'b0) acc_m = res;
      end else if (op == LITERAL_MINUS_ACCUMULATOR_OP) begin
         res = k - acc_m;
         flg_m = '{acc_m <= k, acc_m[3:0] <= k[3:0], res == 8'h00};
         acc_m = res;
      end
      @(negedge clk);
      `CHK("acc", acc_m, acc)
      `CHK("flags", flg_m, flags)
      `CHK("reg_we", we_m, reg_wr.reg_we)
      if (we_m) `CHK("reg_data", res, reg_wr.reg_data)
   endtask : step

   task automatic test_reset();
      rst = 1'b1;
      #5;
      `CHK("rst_out", 20'h0, {reg_wr, acc, flags})
      acc_m = 8'h00;
      flg_m = '0;
      @(negedge clk);
      rst = 1'b0;
      $display("reset test done");
   endtask : test_reset

   task automatic test_rotate();
      step(ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b1, 8'he6);
      step(ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b0, 8'h01);
      step(ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b0, 8'h02);
      step(ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b1, 8'h03);
      step(ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b1, 8'h00);
      $display("rotate test done");
   endtask : test_rotate

   // Boundary literals: equal, nibble borrow, wrap below zero, 255
   task automatic test_sub();
      byte_t ks[7] = '{8'h00, 8'h81, 8'h10, 8'h0f, 8'h00, 8'hff, 8'h05};
      foreach (ks[i]) step(LITERAL_MINUS_ACCUMULATOR_OP, 1'b0, ks[i]);
      step(LITERAL_MINUS_ACCUMULATOR_OP, 1'b1, 8'h3c);
      $display("subtract test done");
   endtask : test_sub

   // Idle keeps accumulator and flags and holds write enable low; a later rotate keeps half carry and zero
   task automatic test_idle();
      step(OP_NONE, 1'b1, 8'hff);
      step(ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b1, 8'h55);
      step(ROTATE_RIGHT_THROUGH_CARRY_OP, 1'b0, 8'h55);
      step(OP_NONE, 1'b0, 8'h00);
      $display("idle test done");
   endtask : test_idle

   initial begin
      rst = 1'b1;
      cmd = '0;
      err_total = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (2) @(negedge clk);
      test_reset();
      test_rotate();
      test_sub();
      test_idle();
      test_reset();
      test_sub();
      tally_and_finish();
   end
endmodule : rot_sub_core_test
`default_nettype wire
